// >>> verilog/wipsl_slave.sv
// Two-wire slave front end with wiper, access-control and storage handling.
//
// What this block does
// - Acts only as slave; master supplies clock and starts transfers.
// - Shifts every byte most significant bit first.
// - Drives data only while clock is low; high-clock changes mean start/stop.
// - Data line released after reset.
// - Ignores the bus until a START is seen.
// - Ignores START during power-up and non-volatile write cycles.
// - STOP after read or volatile write returns straight to standby.
// - STOP after non-volatile write starts timed cycle; standby after.
// - Releases data after 8 bits; acknowledge during ninth clock.
// - Acknowledges valid identification, address and write data bytes.
// - Identification upper seven bits must match; bit 0 selects read.
// - During non-volatile write ignore bus and leave data undriven.
// - Access-control register decides volatile or non-volatile target.
// - Write-protect low discards data byte unacknowledged, back to standby.
// - No register changes unless bytes valid and clock count correct.
// - Data byte latched to wiper or access register at last falling edge.
// - Address 0 with access register zero starts non-volatile write on STOP.
// - Read is write-address then repeated START with read identification.
// - Access-control register selects volatile or non-volatile read source.
// - Volatile select 1 reaches wiper and access register only; 0 reaches stored bytes.
// - Value written into initial-value store also lands in wiper.
// - Wiper and initial-value store share address 0.
// - Wiper resets to 80h, then reloads from stored initial value.
`timescale 1ns/1ps
module wipsl_slave #(
  parameter int NV_CYCLES = wipsl_pkg::NV_WRITE_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wipsl_pkg::wipsl_bus_type busIn,
  input wire logic writeProtect_b,
  output wipsl_pkg::wipsl_drive_type busDrive,
  output logic [7:0] wiper,
  output logic nvBusy
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ID = 3'b001,
    ST_ADDR = 3'b011,
    ST_WDATA = 3'b010,
    ST_RDATA = 3'b110,
    ST_WAITSTOP = 3'b111
  } wipsl_state_type;

  wipsl_state_type state_r;
  logic sclPrev_r;
  logic sdaPrev_r;
  logic [3:0] bitCnt_r;
  logic [7:0] shift_r;
  logic [7:0] addr_r;
  logic [7:0] access_r;
  logic [7:0] txByte_r;
  logic [7:0] wdata_r;
  logic ackPhase_r;
  logic ackDrive_r;
  logic nvPending_r;
  logic [7:0] pwrCnt_r;
  logic recalled_r;
  logic nvStart;
  logic [7:0] nvReadData;
  logic [7:0] nvReadAddr;

  wire logic sclRise = busIn.scl && !sclPrev_r;
  wire logic sclFall = !busIn.scl && sclPrev_r;
  wire logic startCond = sclPrev_r && busIn.scl && sdaPrev_r && !busIn.sda;
  wire logic stopCond = sclPrev_r && busIn.scl && !sdaPrev_r && busIn.sda;
  wire logic poweringUp = !recalled_r;
  wire logic busBlind = nvBusy || poweringUp;
  wire logic volSel = access_r[wipsl_pkg::VOLATILE_SELECT_BIT];

  function automatic logic nv_writable(input logic [7:0] a);
    nv_writable = (a == wipsl_pkg::ADDR_WIPER) ||
      (a >= wipsl_pkg::ADDR_GP_FIRST && a <= wipsl_pkg::ADDR_GP_LAST);
  endfunction : nv_writable

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end else begin
      sclPrev_r <= busIn.scl;
      sdaPrev_r <= busIn.sda;
    end
  end

  // Power-up: wiper holds its reset value until the stored value is recalled.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pwrCnt_r <= 8'h00;
      recalled_r <= 1'b0;
    end else if (!recalled_r) begin
      pwrCnt_r <= pwrCnt_r + 8'h01;
      if (pwrCnt_r == 8'(wipsl_pkg::POWER_UP_CYCLES)) begin
        recalled_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protocol sequencer.  The bit counter runs 0..8; count 8 is the ack slot.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      bitCnt_r <= 4'h0;
      shift_r <= 8'h00;
      addr_r <= 8'h00;
      wdata_r <= 8'h00;
      ackPhase_r <= 1'b0;
      nvPending_r <= 1'b0;
    end else if (busBlind) begin
      state_r <= ST_IDLE;
      bitCnt_r <= 4'h0;
      ackPhase_r <= 1'b0;
      nvPending_r <= 1'b0;
    end else if (startCond) begin
      state_r <= ST_ID;
      bitCnt_r <= 4'h0;
      ackPhase_r <= 1'b0;
      nvPending_r <= 1'b0;
    end else if (stopCond) begin
      state_r <= ST_IDLE;
      bitCnt_r <= 4'h0;
      ackPhase_r <= 1'b0;
      nvPending_r <= 1'b0;
    end else if (state_r != ST_IDLE && state_r != ST_WAITSTOP) begin
      if (sclRise && !ackPhase_r) begin
        shift_r <= {shift_r[6:0], busIn.sda};
        bitCnt_r <= bitCnt_r + 4'h1;
      end else if (sclRise && ackPhase_r && state_r == ST_RDATA && busIn.sda) begin
        state_r <= ST_WAITSTOP;
      end
      if (sclFall && bitCnt_r == 4'h8 && !ackPhase_r) begin
        ackPhase_r <= 1'b1;
        unique case (state_r)
          ST_ID: begin
            if (shift_r[7:1] != wipsl_pkg::SLAVE_PATTERN) begin
              state_r <= ST_WAITSTOP;
            end
          end
          ST_ADDR: addr_r <= shift_r;
          ST_WDATA: begin
            if (!writeProtect_b) begin
              state_r <= ST_IDLE;
            end else begin
              wdata_r <= shift_r;
              nvPending_r <= !volSel && nv_writable(addr_r);
            end
          end
          default: ;
        endcase
      end else if (sclFall && ackPhase_r) begin
        ackPhase_r <= 1'b0;
        bitCnt_r <= 4'h0;
        unique case (state_r)
          ST_ID: state_r <= shift_r[0] ? ST_RDATA : ST_ADDR;
          ST_ADDR: state_r <= ST_WDATA;
          ST_WDATA: state_r <= ST_WAITSTOP;
          default: ;
        endcase
      end
    end
  end

  // Non-volatile cycle launches only on STOP that closes a complete write.
  assign nvStart = stopCond && !busBlind && nvPending_r && state_r == ST_WAITSTOP;

  ////////////////////////////////////////////////////////////////////////////
  // Volatile registers.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      access_r <= wipsl_pkg::ACCESS_RESET;
    end else if (!busBlind && sclFall && bitCnt_r == 4'h8 && !ackPhase_r &&
                 state_r == ST_WDATA && writeProtect_b && addr_r == wipsl_pkg::ADDR_ACCESS) begin
      access_r <= {shift_r[7], 7'h00};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wiper <= wipsl_pkg::WIPER_RESET;
    end else if (!recalled_r && pwrCnt_r == 8'(wipsl_pkg::POWER_UP_CYCLES)) begin
      wiper <= nvReadData;
    end else if (!busBlind && sclFall && bitCnt_r == 4'h8 && !ackPhase_r &&
                 state_r == ST_WDATA && writeProtect_b && addr_r == wipsl_pkg::ADDR_WIPER) begin
      wiper <= shift_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read source selection.
  assign nvReadAddr = recalled_r ? addr_r : wipsl_pkg::ADDR_WIPER;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      txByte_r <= 8'h00;
    end else if (state_r == ST_RDATA && sclFall && ackPhase_r) begin
      txByte_r <= txByte_r;
    end else if (state_r != ST_RDATA || (bitCnt_r == 4'h0 && !ackPhase_r && busIn.scl)) begin
      unique case (addr_r)
        wipsl_pkg::ADDR_WIPER: txByte_r <= volSel ? wiper : nvReadData;
        wipsl_pkg::ADDR_DEVICE_ID: txByte_r <= volSel ? 8'h00 : wipsl_pkg::DEVICE_ID_VALUE;
        wipsl_pkg::ADDR_ACCESS: txByte_r <= access_r;
        default: txByte_r <= (volSel || addr_r == wipsl_pkg::ADDR_RESERVED) ? 8'h00 : nvReadData;
      endcase
    end
  end

  // Open-drain drive decided on falling edges so data moves only with clock low.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ackDrive_r <= 1'b0;
    end else if (busBlind || startCond || stopCond) begin
      ackDrive_r <= 1'b0;
    end else if (sclFall) begin
      if (bitCnt_r == 4'h8 && !ackPhase_r && state_r != ST_RDATA) begin
        ackDrive_r <= (state_r == ST_ID) ? (shift_r[7:1] == wipsl_pkg::SLAVE_PATTERN)
                    : (state_r == ST_WDATA) ? writeProtect_b : (state_r == ST_ADDR);
      end else if (state_r == ST_RDATA && !(bitCnt_r == 4'h8 && !ackPhase_r)) begin
        // Bit 7 leaves on the acknowledge fall, and bit 7-n once n bits have been clocked.
        ackDrive_r <= !txByte_r[3'(4'h7 - (ackPhase_r ? 4'h0 : bitCnt_r))];
      end else if (state_r == ST_ID && ackPhase_r && shift_r[0]) begin
        ackDrive_r <= !txByte_r[7];
      end else begin
        ackDrive_r <= 1'b0;
      end
    end
  end

  assign busDrive.dataOut = 1'b0;
  assign busDrive.dataOe = ackDrive_r;

  wipsl_nv_store #(
    .WRITE_CYCLES(NV_CYCLES)
  ) u_store (
    .clock(clock),
    .rst_b(rst_b),
    .startWrite(nvStart),
    .writeAddr(addr_r),
    .writeData(wdata_r),
    .readAddr(nvReadAddr),
    .readData(nvReadData),
    .busy(nvBusy)
  );

  ////////////////////////////////////////////////////////////////////////////
  property p_blind_release;
    @(posedge clock) disable iff (!rst_b) nvBusy |=> !busDrive.dataOe;
  endproperty
  a_blind_release: assert property (p_blind_release) else $error("drive during nv write");

  property p_drive_clock_low;
    @(posedge clock) disable iff (!rst_b) $changed(busDrive.dataOe) |-> !sclPrev_r || !recalled_r;
  endproperty
  a_drive_clock_low: assert property (p_drive_clock_low) else $error("sda changed scl high");

  property p_wp_no_wiper;
    @(posedge clock) disable iff (!rst_b)
      (recalled_r && !writeProtect_b && !busBlind) |=> $stable(wiper);
  endproperty
  a_wp_no_wiper: assert property (p_wp_no_wiper) else $error("wiper changed under protect");

  property p_start_idle_blind;
    @(posedge clock) disable iff (!rst_b) busBlind |=> state_r == ST_IDLE;
  endproperty
  a_start_idle_blind: assert property (p_start_idle_blind) else $error("start taken blind");

  property p_nv_start_busy;
    @(posedge clock) disable iff (!rst_b) nvStart |=> nvBusy;
  endproperty
  a_nv_start_busy: assert property (p_nv_start_busy) else $error("nv cycle not started");

  property p_access_low_zero;
    @(posedge clock) disable iff (!rst_b) access_r[6:0] == 7'h00;
  endproperty
  a_access_low_zero: assert property (p_access_low_zero) else $error("access bits set");

  property p_nv_start_gate;
    @(posedge clock) disable iff (!rst_b) nvStart |-> !volSel && nv_writable(addr_r);
  endproperty
  a_nv_start_gate: assert property (p_nv_start_gate) else $error("bad nv start");

  property p_stop_idle;
    @(posedge clock) disable iff (!rst_b) (stopCond && !busBlind) |=> state_r == ST_IDLE;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not idle");

  c_nv_write: cover property (@(posedge clock) disable iff (!rst_b) nvStart);
  c_read: cover property (@(posedge clock) disable iff (!rst_b) state_r == ST_RDATA);
  c_wp: cover property (@(posedge clock) disable iff (!rst_b)
    state_r == ST_WDATA && !writeProtect_b && sclFall && bitCnt_r == 4'h8);
endmodule : wipsl_slave

// >>> pkg/wipsl_pkg.sv
// Shared constants and types for the two-wire wiper register slave.
package wipsl_pkg;
  localparam logic [6:0] SLAVE_PATTERN = 7'h28;
  localparam logic [7:0] ADDR_WIPER = 8'h00;
  localparam logic [7:0] ADDR_DEVICE_ID = 8'h01;
  localparam logic [7:0] ADDR_GP_FIRST = 8'h02;
  localparam logic [7:0] ADDR_GP_LAST = 8'h06;
  localparam logic [7:0] ADDR_RESERVED = 8'h07;
  localparam logic [7:0] ADDR_ACCESS = 8'h08;
  localparam int VOLATILE_SELECT_BIT = 7;
  localparam logic [7:0] WIPER_RESET = 8'h80;
  localparam logic [7:0] INITIAL_VALUE_RESET = 8'h80;
  localparam logic [7:0] ACCESS_RESET = 8'h00;
  // Arbitrary neutral identification value.
  localparam logic [7:0] DEVICE_ID_VALUE = 8'h5a;
  localparam int GP_COUNT = 5;
  localparam real NV_WRITE_TIME_US = 5.0;
  localparam int CLOCK_MHZ = 125;
  localparam int NV_WRITE_CYCLES = int'(NV_WRITE_TIME_US * CLOCK_MHZ);
  localparam int POWER_UP_CYCLES = 16;

  typedef struct packed {
    logic scl;
    logic sda;
  } wipsl_bus_type;

  typedef struct packed {
    logic dataOut;
    logic dataOe;
  } wipsl_drive_type;
endpackage : wipsl_pkg

// >>> verilog/wipsl_nv_store.sv
// Non-volatile storage model with a self-timed write cycle.
`timescale 1ns/1ps
module wipsl_nv_store #(
  parameter int WRITE_CYCLES = wipsl_pkg::NV_WRITE_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic startWrite,
  input wire logic [7:0] writeAddr,
  input wire logic [7:0] writeData,
  input wire logic [7:0] readAddr,
  output logic [7:0] readData,
  output logic busy
);
  // The cells are non-volatile, so reset leaves them alone; only factory contents are given.
  logic [7:0] mem_r [0:wipsl_pkg::GP_COUNT] =
    '{0: wipsl_pkg::INITIAL_VALUE_RESET, default: 8'h00};
  logic [7:0] pendAddr_r;
  logic [7:0] pendData_r;
  logic [31:0] count_r;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      busy <= 1'b0;
      count_r <= 32'h0;
      pendAddr_r <= 8'h00;
      pendData_r <= 8'h00;
    end else if (startWrite && !busy) begin
      busy <= 1'b1;
      count_r <= 32'(WRITE_CYCLES);
      pendAddr_r <= writeAddr;
      pendData_r <= writeData;
    end else if (busy) begin
      if (count_r <= 32'h1) begin
        busy <= 1'b0;
      end
      count_r <= count_r - 32'h1;
    end
  end

  // Slot 0 is the initial value store; slots 1..5 are general purpose bytes.
  always_ff @(posedge clock) begin
    if (rst_b && busy && count_r <= 32'h1) begin
      if (pendAddr_r == wipsl_pkg::ADDR_WIPER) begin
        mem_r[0] <= pendData_r;
      end else begin
        mem_r[3'(pendAddr_r - 8'h01)] <= pendData_r;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      readData <= 8'h00;
    end else if (readAddr == wipsl_pkg::ADDR_WIPER) begin
      readData <= mem_r[0];
    end else if (readAddr >= wipsl_pkg::ADDR_GP_FIRST && readAddr <= wipsl_pkg::ADDR_GP_LAST) begin
      readData <= mem_r[3'(readAddr - 8'h01)];
    end else begin
      readData <= 8'h00;
    end
  end
endmodule : wipsl_nv_store

// >>> tb/wipsl_master.sv
// Behavioural two-wire bus master that drives the wiper register slave.
`timescale 1ns/1ps
module wipsl_master (
  input wire logic clock,
  input wire logic sdaWire,
  output logic scl,
  output logic sdaLow
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Each phase spans four system clocks, above the one the slave needs to see a level.
  task automatic phase();
    repeat (4) @(posedge clock);
    #1;
  endtask : phase

  // Serves both the first and a repeated START, so SDA is released with SCL low first.
  task automatic start();
    sdaLow = 1'b0;
    phase();
    scl = 1'b1;
    phase();
    sdaLow = 1'b1;
    phase();
    scl = 1'b0;
    phase();
  endtask : start

  task automatic stop();
    sdaLow = 1'b1;
    phase();
    scl = 1'b1;
    phase();
    sdaLow = 1'b0;
    phase();
  endtask : stop

  // Nine bits: tx then the master's own acknowledge; a released bit lets the slave drive.
  task automatic byteIo(input logic [7:0] tx, input logic ackOut, output logic [7:0] rx,
      output logic ackIn);
    logic [8:0] word;
    word = {tx, ~ackOut};
    for (int i = 8; i >= 0; i--) begin
      sdaLow = ~word[i];
      phase();
      scl = 1'b1;
      phase();
      word[i] = sdaWire;
      phase();
      scl = 1'b0;
      phase();
    end
    sdaLow = 1'b0;
    rx = word[8:1];
    ackIn = ~word[0];
  endtask : byteIo
endmodule : wipsl_master

// >>> tb/tb_wipsl_slave.sv
// Self-checking bench for the two-wire wiper register slave.
`timescale 1ns/1ps
module tb_wipsl_slave;
  localparam int NV = 400;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic writeProtect_b = 1'b1;
  logic scl;
  logic sdaLow;
  logic sdaWire;
  wipsl_pkg::wipsl_bus_type busIn;
  wipsl_pkg::wipsl_drive_type busDrive;
  logic [7:0] wiper;
  logic nvBusy;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  int busyCycles = 0;
  int busyBase = 0;
  logic oeWhileBusy = 1'b0;

  // The data wire has a pull-up, so it reads high unless a party pulls it low.
  assign sdaWire = ~(sdaLow | (busDrive.dataOe & ~busDrive.dataOut));
  assign busIn.scl = scl;
  assign busIn.sda = sdaWire;

  wipsl_slave #(.NV_CYCLES(NV)) u_dut (.clock(clock), .rst_b(rst_b), .busIn(busIn),
    .writeProtect_b(writeProtect_b), .busDrive(busDrive), .wiper(wiper), .nvBusy(nvBusy));
  wipsl_master u_master (.clock(clock), .sdaWire(sdaWire), .scl(scl), .sdaLow(sdaLow));

  initial begin
    forever #4 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (nvBusy === 1'b1) busyCycles <= busyCycles + 1;
    if (nvBusy === 1'b1 && busDrive.dataOe !== 1'b0) oeWhileBusy <= 1'b1;
    if (cycles == 30000) begin
      miscompares++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic sendByte(input string what, input logic [7:0] b, input logic expAck);
    logic [7:0] rx;
    logic ack;
    u_master.byteIo(b, 1'b0, rx, ack);
    check(what, 16'(ack), 16'(expAck));
  endtask : sendByte

  task automatic wrReg(input logic [7:0] addr, input logic [7:0] data, input logic dataAck);
    u_master.start();
    sendByte("write id ack", {wipsl_pkg::SLAVE_PATTERN, 1'b0}, 1'b1);
    sendByte("address ack", addr, 1'b1);
    sendByte("data ack", data, dataAck);
    u_master.stop();
  endtask : wrReg

  task automatic rdReg(input logic [7:0] addr, input logic [7:0] exp, input int count);
    logic [7:0] rx;
    logic ack;
    u_master.start();
    sendByte("write id ack", {wipsl_pkg::SLAVE_PATTERN, 1'b0}, 1'b1);
    sendByte("address ack", addr, 1'b1);
    u_master.start();
    sendByte("read id ack", {wipsl_pkg::SLAVE_PATTERN, 1'b1}, 1'b1);
    for (int i = 1; i <= count; i++) begin
      u_master.byteIo(8'hff, i < count, rx, ack);
      check("read data", 16'(rx), 16'(exp));
    end
    u_master.stop();
    check("released after read", 16'(busDrive.dataOe), 16'h0000);
  endtask : rdReg

  // Bounded wait for the self-timed storage cycle to end.
  task automatic waitIdle();
    for (int i = 0; i < 1000 && nvBusy !== 1'b0; i++) @(posedge clock);
    #1;
  endtask : waitIdle

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clock);
    #1;
    check("wiper at reset", 16'(wiper), 16'(wipsl_pkg::WIPER_RESET));
    check("sda released", 16'(busDrive.dataOe), 16'h0000);
    rst_b = 1'b1;
    repeat (20) @(posedge clock);
    #1;
    u_master.start();
    sendByte("foreign id", 8'ha0, 1'b0);
    u_master.stop();
    wrReg(wipsl_pkg::ADDR_ACCESS, 8'h80, 1'b1);
    wrReg(wipsl_pkg::ADDR_WIPER, 8'h3c, 1'b1);
    check("volatile write busy", 16'(nvBusy), 16'h0000);
    check("wiper volatile", 16'(wiper), 16'h003c);
    rdReg(wipsl_pkg::ADDR_WIPER, 8'h3c, 2);
    rdReg(wipsl_pkg::ADDR_ACCESS, 8'h80, 1);
    writeProtect_b = 1'b0;
    wrReg(wipsl_pkg::ADDR_WIPER, 8'h55, 1'b0);
    writeProtect_b = 1'b1;
    check("protected wiper", 16'(wiper), 16'h003c);
    wrReg(wipsl_pkg::ADDR_ACCESS, 8'h00, 1'b1);
    busyBase = busyCycles;
    wrReg(wipsl_pkg::ADDR_WIPER, 8'ha5, 1'b1);
    check("wiper follows store", 16'(wiper), 16'h00a5);
    check("store write busy", 16'(nvBusy), 16'h0001);
    u_master.start();
    sendByte("id while busy", {wipsl_pkg::SLAVE_PATTERN, 1'b0}, 1'b0);
    u_master.stop();
    waitIdle();
    check("busy length", 16'(busyCycles - busyBase), 16'(NV));
    check("drive while busy", 16'(oeWhileBusy), 16'h0000);
    rdReg(wipsl_pkg::ADDR_WIPER, 8'ha5, 1);
    wrReg(wipsl_pkg::ADDR_DEVICE_ID, 8'h11, 1'b1);
    check("id write busy", 16'(nvBusy), 16'h0000);
    wrReg(wipsl_pkg::ADDR_RESERVED, 8'h22, 1'b1);
    check("reserved write busy", 16'(nvBusy), 16'h0000);
    rdReg(wipsl_pkg::ADDR_DEVICE_ID, wipsl_pkg::DEVICE_ID_VALUE, 1);
    wrReg(wipsl_pkg::ADDR_GP_LAST, 8'h77, 1'b1);
    check("gp write busy", 16'(nvBusy), 16'h0001);
    waitIdle();
    rdReg(wipsl_pkg::ADDR_GP_LAST, 8'h77, 1);
    check("wiper kept", 16'(wiper), 16'h00a5);
    // A second reset must recall the stored initial value into the wiper.
    rst_b = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check("wiper in reset", 16'(wiper), 16'(wipsl_pkg::WIPER_RESET));
    rst_b = 1'b1;
    repeat (22) @(posedge clock);
    #1;
    check("wiper recalled", 16'(wiper), 16'h00a5);
    conclude();
  end
endmodule : tb_wipsl_slave
